// [bench/ack_partner.sv]
/* far-side device model: drives the size acknowledge pair after dly clocks.
   assumes the bench raises go for cycles that end on the external ack. */
`timescale 1ns/1ps
`default_nettype none
module ack_partner (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       go,
    input  wire logic [3:0] dly,
    input  wire logic       w16,
    input  wire logic       bus_done,
    output logic            hi_n,
    output logic            lo_n
);
    // ****************
    // ack answer
    // ****************
    logic [3:0] cnt_r;
    // pins idle high as pulled up; dropped once done is seen
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
            {hi_n, lo_n} <= 2'b11;
        end else if (!go || bus_done) begin
            cnt_r <= 4'h0;
            {hi_n, lo_n} <= 2'b11;
        end else if (cnt_r == dly) begin
            {hi_n, lo_n} <= {1'b0, ~w16};
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // ack_partner
`default_nettype wire

// [bench/testbench.sv]
/* bench: corner and random bus cycles on chip_select, timed by edge counts.
   assumes ack_partner answers cycles waiting on the external ack. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                                 clk = 1'b0;
    logic                                 rstn = 1'b0;
    cs_pkg::bus_req_t                     req = '0;
    cs_pkg::cs_cfg_t [cs_pkg::NUM_CS-1:0] cfg = '0;
    logic [11:0]                          dval = '0;
    logic                                 go = 1'b0;
    logic [3:0]                           dly = 4'h0;
    logic                                 w16 = 1'b0;
    logic                                 hi_n, lo_n, irq, av, done;
    logic [1:0]                           sz;
    logic [11:0]                          cs_n, dout;
    int                                   error_cnt = 0;
    int                                   checks = 0;
    always #4 clk = ~clk;
    chip_select uut (.clk(clk), .rstn(rstn), .req(req), .cs_cfg(cfg), .discrete_val(dval),
        .cycle_size_ack_hi_n(hi_n), .cycle_size_ack_lo_n(lo_n), .cs_n(cs_n),
        .discrete_out(dout), .irq_ack_select(irq), .autovector_request(av),
        .bus_done(done), .ack_size(sz));
    ack_partner far (.clk(clk), .rstn(rstn), .go(go), .dly(dly), .w16(w16),
        .bus_done(done), .hi_n(hi_n), .lo_n(lo_n));
    // ****************
    // tasks
    // ****************
    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] xd();
        for (int k = 0; k < 12; k++)
            xd[k] = cfg[k].pin_mode == cs_pkg::PIN_DISCRETE ? dval[k] : 1'b1;
    endfunction
    // req changes inside the done cycle: an edge change would be retaken
    task automatic run(input int i, input logic wr, input logic ia);
        int n, lo, ir, lim, el;
        logic ext, w, avx, hit;
        cs_pkg::cs_cfg_t c;
        c = cfg[i % 12];
        // unmatched, disabled or wrong-function selects end on the outside ack
        hit = i < 12 && c.en && (ia ? c.func inside {cs_pkg::FN_IRQ_ACK, cs_pkg::FN_AUTOVEC}
                                    : c.func == cs_pkg::FN_SELECT);
        ext = !hit || c.ack_field == cs_pkg::ACK_EXTERNAL;
        avx = hit && ia && c.func == cs_pkg::FN_AUTOVEC;
        lim = c.ack_field == cs_pkg::ACK_FAST ? 1 : 2 + int'(c.ack_field);
        el = !hit || c.pin_mode != cs_pkg::PIN_SELECT ? 0 :
             lim - (c.on_data_strobe && wr ? 3 : 1) + 1;
        el = el < 0 ? 0 : el;
        w = 1'($urandom);
        n = 0;
        lo = 0;
        ir = 0;
        req = '{1'b1, wr, ia, {13'(i), 11'($urandom)}};
        {go, w16, dly} = {ext, w, 4'($urandom_range(0, 9))};
        do begin
            @(posedge clk);
            #1;
            n++;
            lo += int'(cs_n[i % 12] === 1'b0);
            ir += int'(irq === 1'b1);
            check(cs_n | (hit ? 12'h1 << i : 12'h0), 12'hfff);
        end while (done !== 1'b1 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            stop_test();
        end else begin
            if (ext) check(n >= dly + 4 && n <= dly + 6, 1'b1);
            else check(n, lim + 2);
            if (!ext && !avx) check(lo, el);
            if (!avx) check(ir, ia ? el : 0);
            check(av, avx);
            check(sz, avx ? 2'b00 : {1'b1, ext ? w : c.port16});
            check(dout, xd());
        end
        // stale external ack must flush the synchroniser first
        if (ext) begin
            req.valid = 1'b0;
            go = 1'b0;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask
    task automatic cor(input int k, input logic [3:0] af, input logic ds,
                       input cs_pkg::pin_mode_t pm, input logic wr);
        cfg[k].ack_field = af;
        cfg[k].on_data_strobe = ds;
        cfg[k].pin_mode = pm;
        run(k, wr, 1'b0);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        void'($urandom(73741));
        for (int k = 0; k < 12; k++) begin
            cfg[k].en = 1'b1;
            cfg[k].port16 = 1'(k);
            cfg[k].ack_field = 4'(k);
            cfg[k].base = 13'(k);
            cfg[k].mask = 13'h1fff;
        end
        repeat (16) @(posedge clk);
        #1;
        check({cs_n, done, sz, irq, av}, 17'h1ffe0);
        rstn = 1'b1;
        for (int k = 0; k < 12; k++) run(k, 1'($urandom), 1'b0);
        cor(0, 4'hd, 1'b0, cs_pkg::PIN_SELECT, 1'b0);
        cor(0, 4'he, 1'b0, cs_pkg::PIN_SELECT, 1'b1);
        cor(1, 4'h0, 1'b1, cs_pkg::PIN_SELECT, 1'b1);
        cor(1, 4'h5, 1'b1, cs_pkg::PIN_SELECT, 1'b1);
        cor(1, 4'h5, 1'b1, cs_pkg::PIN_SELECT, 1'b0);
        dval = 12'($urandom);
        cor(2, 4'h2, 1'b0, cs_pkg::PIN_DISCRETE, 1'b0);
        cor(3, 4'he, 1'b0, cs_pkg::PIN_ALT, 1'b1);
        cor(4, 4'hf, 1'b0, cs_pkg::PIN_SELECT, 1'b0);
        run(12, 1'b0, 1'b0);
        cfg[5].func = cs_pkg::FN_OFF;
        run(5, 1'b1, 1'b0);
        cfg[5].func = cs_pkg::FN_SELECT;
        cfg[6].en = 1'b0;
        run(6, 1'b0, 1'b0);
        cfg[6].en = 1'b1;
        run(3, 1'b0, 1'b1);
        cfg[10].func = cs_pkg::FN_IRQ_ACK;
        cfg[11].func = cs_pkg::FN_AUTOVEC;
        run(10, 1'b0, 1'b1);
        run(11, 1'b0, 1'b1);
        // reset in mid-cycle drops the live select at once
        req = '{1'b1, 1'b0, 1'b0, {13'h0009, 11'h000}};
        repeat (4) @(posedge clk);
        #1;
        check(cs_n[9], 1'b0);
        rstn = 1'b0;
        #1;
        check({cs_n, done, sz, irq, av}, 17'h1ffe0);
        req.valid = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (60) begin
            dval = 12'($urandom);
            cfg[0].port16 = 1'($urandom);
            cor($urandom_range(0, 9), 4'($urandom), 1'($urandom),
                $urandom_range(0, 3) == 0 ? cs_pkg::PIN_DISCRETE : cs_pkg::PIN_SELECT,
                1'($urandom));
        end
        stop_test();
    end
endmodule // testbench
`default_nettype wire

// [design/chip_select.sv]
/*
 * chip-select unit: twelve selects, internal/external acknowledge, wait states.
 * assumes the core holds req stable until bus_done; ack pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module chip_select (
    input  wire logic                                       clk,
    input  wire logic                                       rstn,
    input  wire cs_pkg::bus_req_t                           req,
    input  wire cs_pkg::cs_cfg_t [cs_pkg::NUM_CS-1:0]       cs_cfg,
    input  wire logic [cs_pkg::NUM_CS-1:0]                  discrete_val,
    input  wire logic                                       cycle_size_ack_hi_n,
    input  wire logic                                       cycle_size_ack_lo_n,
    output logic [cs_pkg::NUM_CS-1:0]                       cs_n,
    output logic [cs_pkg::NUM_CS-1:0]                       discrete_out,
    output logic                                            irq_ack_select,
    output logic                                            autovector_request,
    output logic                                            bus_done,
    output logic [1:0]                                      ack_size
);
    // ************************************************************
    // state
    // ************************************************************
    cs_pkg::cs_state_t s_r;
    cs_pkg::cs_state_t s_nxt;
    logic              ack_seen;
    logic              fin;
    logic              match_hit;
    logic [3:0]        match_idx;
    cs_pkg::cs_cfg_t   mc;

    assign ack_seen = ~&s_r.sy2;

    // ************************************************************
    // address decode, lowest index wins
    // ************************************************************
    always_comb begin
        match_hit = 1'b0;
        match_idx = 4'h0;
        for (int i = cs_pkg::NUM_CS - 1; i >= 0; i--) begin
            if (cs_cfg[i].en &&
                ((req.addr[cs_pkg::ADDR_W-1:cs_pkg::MATCH_LSB] & cs_cfg[i].mask) ==
                 (cs_cfg[i].base & cs_cfg[i].mask)) &&
                (req.irq_ack ? (cs_cfg[i].func == cs_pkg::FN_IRQ_ACK ||
                             cs_cfg[i].func == cs_pkg::FN_AUTOVEC)
                          : (cs_cfg[i].func == cs_pkg::FN_SELECT))) begin
                match_hit = 1'b1;
                match_idx = 4'(i);
            end
        end
        mc = cs_cfg[match_idx];
    end

    // ************************************************************
    // cycle sequencer
    // ************************************************************
    always_comb begin
        s_nxt          = s_r;
        s_nxt.sy1      = {cycle_size_ack_hi_n, cycle_size_ack_lo_n};
        s_nxt.sy2      = s_r.sy1;
        s_nxt.done     = 1'b0;
        s_nxt.ack      = 2'h0;
        s_nxt.autovec_req = 1'b0;
        s_nxt.cs_n     = '1;
        s_nxt.irq_sel  = 1'b0;
        fin            = 1'b0;
        unique case (s_r.st)
            cs_pkg::BUS_IDLE: begin
                if (req.valid) begin
                    s_nxt.st     = cs_pkg::BUS_RUN;
                    s_nxt.cnt    = 5'h00;
                    s_nxt.hit    = match_hit;
                    s_nxt.sel    = match_idx;
                    s_nxt.port16 = mc.port16;
                    s_nxt.autovec = mc.func == cs_pkg::FN_AUTOVEC;
                    s_nxt.irq_ack = req.irq_ack;
                    // unmatched cycles fall back to the outside acknowledge
                    s_nxt.ext    = !match_hit || mc.ack_field == cs_pkg::ACK_EXTERNAL;
                    if (mc.ack_field == cs_pkg::ACK_FAST)
                        s_nxt.lim = cs_pkg::FAST_LAST;
                    else if (mc.ack_field <= cs_pkg::ACK_MAX_WAIT)
                        s_nxt.lim = cs_pkg::BASE_LAST + {1'b0, mc.ack_field};
                    else
                        s_nxt.lim = cs_pkg::BASE_LAST;
                    s_nxt.pt = (mc.on_data_strobe && req.write) ?
                               cs_pkg::PT_ADDR_STB + cs_pkg::DATA_STB_DLY :
                               cs_pkg::PT_ADDR_STB;
                end
            end
            cs_pkg::BUS_RUN: begin
                fin = s_r.ext ? (ack_seen && s_r.cnt >= cs_pkg::BASE_LAST)
                              : (s_r.cnt == s_r.lim);
                if (fin) begin
                    s_nxt.st   = cs_pkg::BUS_IDLE;
                    s_nxt.done = 1'b1;
                    if (!s_r.ext && s_r.hit) begin
                        // ack is made even when the pin is not a select
                        if (s_r.autovec && s_r.irq_ack)
                            s_nxt.autovec_req = 1'b1;
                        else
                            s_nxt.ack = {1'b1, s_r.port16};
                    end else begin
                        s_nxt.ack = ~s_r.sy2;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    // write with data-strobe timing and no waits never reaches pt
                    if (s_r.hit && (s_r.cnt + 5'h01) >= s_r.pt &&
                        cs_cfg[s_r.sel].pin_mode == cs_pkg::PIN_SELECT) begin
                        s_nxt.cs_n[s_r.sel] = 1'b0;
                        s_nxt.irq_sel       = s_r.irq_ack;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: cs_pkg::BUS_IDLE, cs_n: '1, sy1: '1, sy2: '1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cs_n               = s_r.cs_n;
    assign irq_ack_select     = s_r.irq_sel;
    assign autovector_request = s_r.autovec_req;
    assign bus_done           = s_r.done;
    assign ack_size           = s_r.ack;

    always_comb begin
        for (int i = 0; i < cs_pkg::NUM_CS; i++) begin
            discrete_out[i] = (cs_cfg[i].pin_mode == cs_pkg::PIN_DISCRETE) ?
                              discrete_val[i] : 1'b1;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    AST_ONE_SELECT: assert property (@(posedge clk) disable iff (!rstn)
        $onehot0(~cs_n)) else $error("more than one select asserted");

    AST_PIN_MODE: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && s_r.hit &&
        cs_cfg[s_r.sel].pin_mode != cs_pkg::PIN_SELECT |-> cs_n[s_r.sel])
        else $error("select driven while pin reassigned");

    AST_WAIT_LIMIT: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_IDLE && req.valid && match_hit &&
        mc.ack_field <= cs_pkg::ACK_MAX_WAIT
        |=> s_r.lim == cs_pkg::BASE_LAST + {1'b0, $past(mc.ack_field)} && !s_r.ext)
        else $error("wait limit not three clocks plus waits");

    AST_FAST_TERM: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_IDLE && req.valid && match_hit &&
        mc.ack_field == cs_pkg::ACK_FAST |=> s_r.lim == cs_pkg::FAST_LAST)
        else $error("fast termination limit wrong");

    AST_INT_DONE: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && !s_r.ext && s_r.cnt == s_r.lim
        |=> bus_done && s_r.st == cs_pkg::BUS_IDLE)
        else $error("internal ack not issued at limit");

    AST_NO_EARLY_DONE: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && !s_r.ext && s_r.cnt < s_r.lim |=> !bus_done)
        else $error("ack issued before wait states elapsed");

    AST_EXT_WAIT: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && s_r.ext && !ack_seen |=> !bus_done)
        else $error("external cycle ended without ack");

    AST_RESTART: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_IDLE && req.valid |=> s_r.cnt == 5'h00 ##1 s_r.cnt <= 5'h01)
        else $error("wait counter not restarted");

    AST_DATA_STB_WRITE: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_IDLE && req.valid && match_hit && mc.on_data_strobe && req.write
        |=> (&cs_n) [*3])
        else $error("data strobe write select too early");

    AST_AUTOVEC: assert property (@(posedge clk) disable iff (!rstn)
        autovector_request |-> bus_done && ack_size == 2'h0)
        else $error("autovector with size ack");

    AST_ADDR_STB_SEL: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_IDLE && req.valid && match_hit &&
        mc.pin_mode == cs_pkg::PIN_SELECT && !(mc.on_data_strobe && req.write)
        |=> &cs_n ##1 !cs_n[$past(match_idx, 2)])
        else $error("address strobe select not in second bus state");

    AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        bus_done |=> !bus_done)
        else $error("bus done longer than one clock");

    AST_EXT_ACK: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && s_r.ext && ack_seen && s_r.cnt >= cs_pkg::BASE_LAST
        |=> bus_done && ack_size == ~$past(s_r.sy2))
        else $error("external ack not passed through");

    AST_INT_SIZE: assert property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && !s_r.ext && s_r.cnt == s_r.lim && !s_r.irq_ack
        |=> ack_size == {1'b1, $past(cs_cfg[s_r.sel].port16)})
        else $error("internal size ack wrong");

    COV_ZERO_WAIT: cover property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && !s_r.ext && s_r.lim == cs_pkg::BASE_LAST ##[1:3] bus_done);
    COV_FAST: cover property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && s_r.lim == cs_pkg::FAST_LAST && !s_r.ext ##2 bus_done);
    COV_EXT: cover property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && s_r.ext ##[1:20] bus_done);
    COV_AUTOVEC: cover property (@(posedge clk) disable iff (!rstn) autovector_request);
    COV_DATA_STB_SEL: cover property (@(posedge clk) disable iff (!rstn)
        s_r.st == cs_pkg::BUS_RUN && s_r.pt != cs_pkg::PT_ADDR_STB && !(&cs_n));
endmodule // chip_select
`default_nettype wire

// [pkg/cs_pkg.sv]
/*
 * chip-select package: config layout, ack field codes, cycle timing counts.
 * assumes a 24-bit core address and a three-clock base bus cycle.
 */
`default_nettype none
package cs_pkg;
    localparam int           NUM_CS       = 12;
    localparam int           ADDR_W       = 24;
    localparam int           MATCH_W      = 13;
    localparam int           MATCH_LSB    = 11;
    localparam logic [3:0]   ACK_MAX_WAIT = 4'hd;
    localparam logic [3:0]   ACK_FAST     = 4'he;
    localparam logic [3:0]   ACK_EXTERNAL = 4'hf;
    localparam logic [4:0]   BASE_LAST    = 5'h02;
    localparam logic [4:0]   FAST_LAST    = 5'h01;
    localparam logic [4:0]   PT_ADDR_STB  = 5'h01;
    localparam logic [4:0]   DATA_STB_DLY = 5'h02;

    typedef enum logic [1:0] {PIN_SELECT, PIN_DISCRETE, PIN_ALT} pin_mode_t;
    typedef enum logic [1:0] {FN_SELECT, FN_IRQ_ACK, FN_AUTOVEC, FN_OFF} cs_func_t;
    typedef enum logic {BUS_IDLE, BUS_RUN} bus_state_t;

    typedef struct packed {
        logic                 en;
        pin_mode_t            pin_mode;
        cs_func_t             func;
        logic                 port16;
        logic                 on_data_strobe;
        logic [3:0]           ack_field;
        logic [MATCH_W-1:0]   base;
        logic [MATCH_W-1:0]   mask;
    } cs_cfg_t;

    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic                 irq_ack;
        logic [ADDR_W-1:0]    addr;
    } bus_req_t;

    typedef struct packed {
        bus_state_t           st;
        logic [4:0]           cnt;
        logic [4:0]           lim;
        logic [4:0]           pt;
        logic                 ext;
        logic                 hit;
        logic [3:0]           sel;
        logic                 port16;
        logic                 autovec;
        logic                 irq_ack;
        logic [NUM_CS-1:0]    cs_n;
        logic                 irq_sel;
        logic                 done;
        logic [1:0]           ack;
        logic                 autovec_req;
        logic [1:0]           sy1;
        logic [1:0]           sy2;
    } cs_state_t;
endpackage
`default_nettype wire
